// File: cmp_pkg.sv
package cmp_pkg;
	localparam int NUM_CH = 3;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL0  = 8'h00;
	localparam logic [7:0] OFF_CTRL1  = 8'h04;
	localparam logic [7:0] OFF_CTRL2  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_EVENT  = 8'h10;
	localparam logic [7:0] OFF_MASK   = 8'h14;
	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int BIT_ENABLE    = 15;
	localparam int BIT_PIN_DRIVE = 14;
	localparam int BIT_INVERT    = 13;
	localparam int BIT_RESULT    = 8;
	localparam int BIT_EDGE_HI   = 7;
	localparam int BIT_EDGE_LO   = 6;
	localparam int BIT_POS_SEL   = 4;
	localparam int BIT_NEG_HI    = 1;
	localparam int BIT_NEG_LO    = 0;
	localparam int BIT_HALT_IDLE = 13;
	localparam logic [31:0] CTRL_WMASK  = 32'h0000_e0d3;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_00c3;
	localparam logic [1:0]  EDGE_OFF    = 2'h0;
	localparam logic [1:0]  EDGE_RISE   = 2'h1;
	localparam logic [1:0]  EDGE_FALL   = 2'h2;
	localparam logic [1:0]  EDGE_BOTH   = 2'h3;
	localparam logic [1:0]  NEG_PIN_B   = 2'h0;
	localparam logic [1:0]  NEG_PIN_C   = 2'h1;
	localparam logic [1:0]  NEG_PIN_D   = 2'h2;
	localparam logic [1:0]  NEG_ABS_REF = 2'h3;
	localparam logic [1:0]  POS_PIN_A   = 2'h0;
	localparam logic [1:0]  POS_LADDER  = 2'h1;
endpackage : cmp_pkg

// File: cmp_chan_if.sv
`timescale 1ns/1ps
interface cmp_chan_if;
	logic       enable;
	logic       invert;
	logic [1:0] edgeSelect;
	logic       rawResult;
	logic       level;
	logic       edgeEvent;
	modport ctl (output enable, output invert, output edgeSelect, output rawResult,
		input level, input edgeEvent);
	modport chan (input enable, input invert, input edgeSelect, input rawResult,
		output level, output edgeEvent);
endinterface : cmp_chan_if

// File: cmp_channel.sv
`timescale 1ns/1ps
// synchronised, inverted result with edge detection for one channel
module cmp_channel (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	cmp_chan_if.chan  port
);
	logic [2:0] syncStage;
	logic       prevLevel;
	logic       stable;

	// three stages; change accepted when stages two and three agree
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			syncStage <= 3'h0;
		end else begin
			syncStage <= {syncStage[1:0], port.rawResult};
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stable <= 1'b0;
		end else if (syncStage[1] == syncStage[2]) begin
			stable <= syncStage[2];
		end
	end

	// inversion feeds both the readback and the edge detector
	assign port.level = port.enable & (stable ^ port.invert);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prevLevel <= 1'b0;
		end else begin
			prevLevel <= port.level;
		end
	end

	always_comb begin
		unique case (port.edgeSelect)
			cmp_pkg::EDGE_OFF:  port.edgeEvent = 1'b0;
			cmp_pkg::EDGE_RISE: port.edgeEvent = port.level & ~prevLevel;
			cmp_pkg::EDGE_FALL: port.edgeEvent = ~port.level & prevLevel;
			cmp_pkg::EDGE_BOTH: port.edgeEvent = port.level ^ prevLevel;
		endcase
	end

	a_rise_event: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(port.edgeSelect == cmp_pkg::EDGE_RISE && port.edgeEvent) |-> !$past(port.level))
		else $error("rise event without prior low level");
	a_off_silent: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(port.edgeSelect == cmp_pkg::EDGE_OFF) |-> !port.edgeEvent)
		else $error("event while edge select off");
endmodule : cmp_channel

// File: analog_comparator_control.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module analog_comparator_control (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        systemIdle,
	input  wire logic [2:0]  rawResult,
	output logic      [2:0]  channelPower,
	output logic      [2:0]  positiveInputSelect,
	output logic      [5:0]  negativeInputSelect,
	output logic      [2:0]  resultPin,
	output logic      [2:0]  resultPinOe,
	output logic      [2:0]  irqRequest,
	output logic             irq
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [31:0] ctrl [cmp_pkg::NUM_CH];
	logic        haltWhenIdle;
	logic [2:0]  eventStatus;
	logic [2:0]  eventMask;
	logic [2:0]  level;
	logic [2:0]  chanEvent;
	logic [2:0]  active;
	logic        wrAccess;
	logic        rdAccess;
	logic        unmapped;
	logic [31:0] next_prdata;

	assign wrAccess = psel & penable & pwrite;
	assign rdAccess = psel & penable & ~pwrite;
	assign pready   = 1'b1;
	assign unmapped = !(paddr inside {cmp_pkg::OFF_CTRL0, cmp_pkg::OFF_CTRL1,
		cmp_pkg::OFF_CTRL2, cmp_pkg::OFF_STATUS, cmp_pkg::OFF_EVENT, cmp_pkg::OFF_MASK});
	assign pslverr  = psel & penable & unmapped;

	// ------------------------------------------------------------
	// per-channel logic
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < cmp_pkg::NUM_CH; g++) begin : gen_ch
			cmp_chan_if chIf ();
			logic [7:0] chAddr;
			assign chAddr = cmp_pkg::OFF_CTRL0 + 8'(4 * g);

			// only writable bits change; every write, enable writes included, loads all writable fields from pwdata
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					ctrl[g] <= cmp_pkg::CTRL_RESET;
				end else if (wrAccess && paddr == chAddr) begin
					ctrl[g] <= pwdata & cmp_pkg::CTRL_WMASK;
				end
			end

			// idle halt gates the channel like a cleared enable
			assign active[g] = ctrl[g][cmp_pkg::BIT_ENABLE]
				& ~(haltWhenIdle & systemIdle);
			assign chIf.enable     = active[g];
			assign chIf.invert     = ctrl[g][cmp_pkg::BIT_INVERT];
			assign chIf.edgeSelect = ctrl[g][cmp_pkg::BIT_EDGE_HI:cmp_pkg::BIT_EDGE_LO];
			assign chIf.rawResult  = rawResult[g];
			assign level[g]        = chIf.level;
			assign chanEvent[g]    = chIf.edgeEvent;

			cmp_channel u_channel (
				.clk_sys (clk_sys),
				.arst_n  (arst_n),
				.port    (chIf.chan)
			);

			assign channelPower[g]        = active[g];
			assign positiveInputSelect[g] = ctrl[g][cmp_pkg::BIT_POS_SEL];
			assign negativeInputSelect[2*g+1:2*g] =
				ctrl[g][cmp_pkg::BIT_NEG_HI:cmp_pkg::BIT_NEG_LO];

			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					resultPin[g]   <= 1'b0;
					resultPinOe[g] <= 1'b0;
				end else begin
					resultPin[g]   <= level[g];
					resultPinOe[g] <= ctrl[g][cmp_pkg::BIT_PIN_DRIVE] & active[g];
				end
			end

			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					irqRequest[g] <= 1'b0;
				end else begin
					irqRequest[g] <= chanEvent[g];
				end
			end

			// set wins over a simultaneous write-one clear
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					eventStatus[g] <= 1'b0;
				end else if (chanEvent[g]) begin
					eventStatus[g] <= 1'b1;
				end else if (wrAccess && paddr == cmp_pkg::OFF_EVENT && pwdata[g]) begin
					eventStatus[g] <= 1'b0;
				end
			end

			a_pulse_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
				irqRequest[g] |=> !irqRequest[g] || $past(chanEvent[g]))
				else $error("request not tied to event");
			a_pin_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
				!ctrl[g][cmp_pkg::BIT_PIN_DRIVE] |=> !resultPinOe[g])
				else $error("pin driven while drive bit clear");
			a_idle_halt: assert property (@(posedge clk_sys) disable iff (!arst_n)
				(haltWhenIdle && systemIdle) |-> !channelPower[g])
				else $error("channel powered in idle with halt set");
		end
	endgenerate

	// ------------------------------------------------------------
	// shared registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			haltWhenIdle <= 1'b0;
		end else if (wrAccess && paddr == cmp_pkg::OFF_STATUS) begin
			haltWhenIdle <= pwdata[cmp_pkg::BIT_HALT_IDLE];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			eventMask <= 3'h0;
		end else if (wrAccess && paddr == cmp_pkg::OFF_MASK) begin
			eventMask <= pwdata[2:0];
		end
	end

	assign irq = |(eventStatus & eventMask);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		next_prdata = 32'h0;
		unique case (paddr)
			cmp_pkg::OFF_CTRL0: begin
				next_prdata = ctrl[0];
				next_prdata[cmp_pkg::BIT_RESULT] = level[0];
			end
			cmp_pkg::OFF_CTRL1: begin
				next_prdata = ctrl[1];
				next_prdata[cmp_pkg::BIT_RESULT] = level[1];
			end
			cmp_pkg::OFF_CTRL2: begin
				next_prdata = ctrl[2];
				next_prdata[cmp_pkg::BIT_RESULT] = level[2];
			end
			cmp_pkg::OFF_STATUS: begin
				next_prdata[cmp_pkg::BIT_HALT_IDLE] = haltWhenIdle;
				next_prdata[2:0] = level;
			end
			cmp_pkg::OFF_EVENT: next_prdata[2:0] = eventStatus;
			cmp_pkg::OFF_MASK:  next_prdata[2:0] = eventMask;
			default:            next_prdata = 32'h0;
		endcase
	end

	// read data registered in the setup cycle, valid in the access cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	a_status_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(psel && !penable && !pwrite && paddr == cmp_pkg::OFF_STATUS)
		|=> prdata[2:0] == $past(level))
		else $error("status does not mirror results");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
		rdAccess |-> prdata[31:16] == 16'h0)
		else $error("reserved bits read nonzero");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
		irq == |(eventStatus & eventMask))
		else $error("irq disagrees with status");
endmodule : analog_comparator_control

// File: comparator_cores.sv
`timescale 1ns/1ps
// ----------------------------------------
// analog comparator cores, one per channel
// ----------------------------------------
module comparator_cores (
	input  wire logic        clk_sys,
	input  wire logic [2:0]  channelPower,
	input  wire logic [2:0]  positiveInputSelect,
	input  wire logic [5:0]  negativeInputSelect,
	input  wire logic [47:0] pins,
	output logic      [2:0]  rawResult
);
	// pins per channel: a 3:0, b 7:4, c 11:8, d 15:12
	localparam logic [3:0] LADDER  = 4'h8;
	localparam logic [3:0] ABS_REF = 4'h5;
	logic [3:0] plus;
	logic [3:0] minus;
	logic [1:0] sel;
	logic       toggle = 1'b0;
	// an unpowered core gives no stable level, so it wanders
	always_ff @(posedge clk_sys) begin
		toggle <= ~toggle;
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sel = negativeInputSelect[2*i +: 2];
			plus = positiveInputSelect[i] ? LADDER : pins[16*i +: 4];
			minus = (sel == 2'h3) ? ABS_REF : pins[16*i + 4*(sel + 1) +: 4];
			rawResult[i] = channelPower[i] ? (plus > minus) : (toggle ^ i[0]);
		end
	end
endmodule : comparator_cores

// File: tb_analog_comparator_control.sv
`timescale 1ns/1ps
module tb_analog_comparator_control;
	localparam logic [3:0] TAB = 4'b1101;
	logic        clk_sys    = 1'b0;
	logic        arst_n     = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic        systemIdle = 1'b0;
	logic [47:0] pins       = 48'h0;
	logic [31:0] prdata, rd, ctrl;
	logic        pready, pslverr, irq, slvErr, riseExp, fallExp;
	logic [2:0]  rawResult, channelPower, positiveInputSelect;
	logic [2:0]  resultPin, resultPinOe, irqRequest;
	logic [5:0]  negativeInputSelect;
	int          errors = 0;
	int          checks = 0;
	int          cycles = 0;
	int          reqCount = 0;
	analog_comparator_control u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .systemIdle, .rawResult, .channelPower,
		.positiveInputSelect, .negativeInputSelect, .resultPin, .resultPinOe,
		.irqRequest, .irq);
	comparator_cores u_cores (.clk_sys, .channelPower, .positiveInputSelect,
		.negativeInputSelect, .pins, .rawResult);
	initial forever #20 clk_sys = ~clk_sys;
	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// result path is 3 sync stages and the stable register plus one for the event
	task automatic settle;
		repeat (8) @(posedge clk_sys);
	endtask : settle
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (irqRequest[2]) reqCount <= reqCount + 1;
		if (cycles == 3000) begin
			errors++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check(rd, 32'h0000_00c3);
		end
		apb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		check({rd[31:1], slvErr}, 32'h1);
		apb(1'b1, 8'h00, 32'hffff_ffff);
		settle;
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h0000_e0d3);
		check({resultPinOe[0], resultPin[0], positiveInputSelect[0], negativeInputSelect[1:0]},
			32'h17);
		apb(1'b1, 8'h00, 32'h0000_60d3);
		settle;
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h0000_60d3);
		check({channelPower[0], resultPinOe[0]}, 32'h0);
		pins[31:16] <= 16'h4926;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 8'h04, 32'h8000 | s);
			settle;
			apb(1'b0, 8'h0c, 32'h0);
			check(rd[1], TAB[s]);
			apb(1'b0, 8'h04, 32'h0);
			check(rd[8], TAB[s]);
		end
		pins[39:36] <= 4'h7;
		apb(1'b1, 8'h14, 32'h4);
		for (int m = 0; m < 8; m++) begin
			ctrl = 32'h8000 | (32'(m & 4) << 11) | (32'(m & 3) << 6);
			riseExp = m[2] ? m[1] : m[0];
			fallExp = m[2] ? m[0] : m[1];
			apb(1'b1, 8'h08, ctrl);
			settle;
			apb(1'b1, 8'h10, 32'h7);
			reqCount = 0;
			pins[35:32] <= 4'hf;
			settle;
			check(reqCount, riseExp);
			apb(1'b0, 8'h10, 32'h0);
			check(rd, {riseExp, 2'b00});
			check(irq, riseExp);
			apb(1'b1, 8'h10, 32'h7);
			reqCount = 0;
			pins[35:32] <= 4'h0;
			settle;
			check(reqCount, fallExp);
			check(irq, fallExp);
			apb(1'b0, 8'h10, 32'h0);
			check(rd, {fallExp, 2'b00});
		end
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h10, 32'h7);
		pins[35:32] <= 4'hf;
		settle;
		check(irq, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h4);
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		systemIdle <= 1'b1;
		settle;
		check(channelPower, 3'b000);
		systemIdle <= 1'b0;
		settle;
		check(channelPower, 3'b110);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0000_2002);
		print_verdict;
	end
endmodule : tb_analog_comparator_control
